// ==== logic/mffsr_pkg.sv ====
// Purpose: shared types and constants of the memory feature and
//          instruction fault status register bank
// Assumes: one coprocessor transfer per request, processor clock domain
// Notes:   field values are fixed by the memory model profile
package mffsr_pkg;

    // ------------------------------------------------------------
    // transfer encodings
    // ------------------------------------------------------------
    localparam logic [3:0] CP_SYSTEM = 4'hf;
    localparam logic [1:0] LEVEL_ONE = 2'h1;
    localparam logic [2:0] FEAT_OPC1 = 3'h0;
    localparam logic [3:0] FEAT_CRN = 4'h0;
    localparam logic [3:0] FEAT_CRM = 4'h1;
    localparam logic [2:0] FEAT_OPC2 = 3'h6;
    localparam logic [2:0] FLT_OPC1 = 3'h0;
    localparam logic [3:0] FLT_CRN = 4'h5;
    localparam logic [3:0] FLT_CRM = 4'h0;
    localparam logic [2:0] FLT_OPC2 = 3'h1;

    // ------------------------------------------------------------
    // feature word fields
    // ------------------------------------------------------------
    localparam int HWACC_LSB = 28;
    localparam int STALL_LSB = 24;
    localparam int BARR_LSB = 20;
    localparam int UTLB_LSB = 16;
    localparam int STLB_LSB = 12;
    localparam int RANGE_LSB = 8;
    localparam int BGF_LSB = 4;
    localparam int FGF_LSB = 0;
    localparam logic [3:0] HWACC_VAL = 4'h0;
    localparam logic [3:0] STALL_NONE = 4'h0;
    localparam logic [3:0] STALL_YES = 4'h1;
    localparam logic [3:0] BARR_VAL = 4'h2;
    localparam logic [3:0] UTLB_VAL = 4'h0;
    localparam logic [3:0] STLB_VAL = 4'h0;
    localparam logic [3:0] RANGE_VAL = 4'h0;
    localparam logic [3:0] BGF_VAL = 4'h0;
    localparam logic [3:0] FGF_VAL = 4'h0;

    // ------------------------------------------------------------
    // fault status fields and encodings
    // ------------------------------------------------------------
    localparam int ADDR_INV_BIT = 16;
    localparam int CLASS_BIT = 12;
    localparam int LONG_DESC_BIT = 9;
    localparam logic [5:0] ST_TRANSLATION = 6'h04;
    localparam logic [5:0] ST_PERMISSION = 6'h0c;
    localparam logic [5:0] ST_SYNC_EXT = 6'h10;
    localparam logic [5:0] ST_PARITY = 6'h18;
    localparam logic [5:0] ST_PC_ALIGN = 6'h21;
    localparam logic [5:0] ST_DEBUG = 6'h22;

    typedef enum logic [1:0] {
        TGT_NONE = 2'b00,
        TGT_FEATURE = 2'b01,
        TGT_FAULT = 2'b10
    } mffsr_target_type;

    typedef struct packed {
        logic write;
        logic [1:0] level;
        logic [3:0] coproc;
        logic [2:0] opc1;
        logic [3:0] crn;
        logic [3:0] crm;
        logic [2:0] opc2;
        logic [31:0] wdata;
    } mffsr_req_type;

    typedef struct packed {
        logic hypervisor_level;
        logic id_group3_trap;
        logic primary_reg0_trap;
        logic memory_control_write_trap;
        logic memory_control_read_trap;
        logic primary_reg5_trap;
    } mffsr_trap_ctl_type;

    typedef struct packed {
        logic valid;
        logic [5:0] status;
        logic abort_classification_bit;
        logic fault_address_invalid;
    } mffsr_fault_type;

    function automatic logic mffsr_status_legal(input logic [5:0] s);
        return (s == ST_TRANSLATION) || (s == ST_PERMISSION) ||
               (s == ST_SYNC_EXT) || (s == ST_PARITY) ||
               (s == ST_PC_ALIGN) || (s == ST_DEBUG);
    endfunction : mffsr_status_legal

    function automatic logic mffsr_is_external(input logic [5:0] s);
        return (s == ST_SYNC_EXT) || (s == ST_PARITY);
    endfunction : mffsr_is_external

endpackage : mffsr_pkg

// ==== logic/mffsr_trap_chk.sv ====
// Purpose: decide whether a level 1 access must go to the hypervisor
// Assumes: target already decoded by the caller
// Notes:   purely combinational, no state
module mffsr_trap_chk (
    input wire mffsr_pkg::mffsr_target_type target_i,
    input wire logic write_i,
    input wire logic [1:0] level_i,
    input wire mffsr_pkg::mffsr_trap_ctl_type ctl_i,
    output logic trap_o
);
    logic guarded;

    always_comb begin
        guarded = ctl_i.hypervisor_level && (level_i == mffsr_pkg::LEVEL_ONE);
        trap_o = 1'b0;
        case (target_i)
            mffsr_pkg::TGT_FEATURE: begin
                trap_o = guarded && !write_i &&
                         (ctl_i.id_group3_trap || ctl_i.primary_reg0_trap);
            end
            mffsr_pkg::TGT_FAULT: begin
                trap_o = guarded && (ctl_i.primary_reg5_trap ||
                         (write_i && ctl_i.memory_control_write_trap) ||
                         (!write_i && ctl_i.memory_control_read_trap));
            end
            default: begin
                trap_o = 1'b0;
            end
        endcase
    end
endmodule : mffsr_trap_chk

// ==== logic/mffsr_fault_rec.sv ====
// Purpose: instruction fault status storage
// Assumes: fault report and software write may meet in one cycle
// Notes:   a fetch fault beats a software write in the same cycle
module mffsr_fault_rec (
    input wire logic ref_clk_i,
    input wire mffsr_pkg::mffsr_fault_type fault_i,
    input wire logic sw_we_i,
    input wire logic [31:0] sw_wdata_i,
    output logic [31:0] value_o
);
    logic [5:0] status_r;
    logic addr_inv_r;
    logic class_r;
    logic [5:0] ws;

    assign ws = sw_wdata_i[5:0];

    always_ff @(posedge ref_clk_i) begin
        if (fault_i.valid) begin
            status_r <= fault_i.status;
            // invalid flag only on sync external
            addr_inv_r <= (fault_i.status == mffsr_pkg::ST_SYNC_EXT) &&
                          fault_i.fault_address_invalid;
            class_r <= mffsr_pkg::mffsr_is_external(fault_i.status) &&
                     fault_i.abort_classification_bit;
        end else if (sw_we_i) begin
            if (mffsr_pkg::mffsr_status_legal(ws)) begin
                status_r <= ws;
            end
            addr_inv_r <= (ws == mffsr_pkg::ST_SYNC_EXT) &&
                          sw_wdata_i[mffsr_pkg::ADDR_INV_BIT];
            class_r <= mffsr_pkg::mffsr_is_external(ws) &&
                       sw_wdata_i[mffsr_pkg::CLASS_BIT];
        end
    end

    always_comb begin
        value_o = '0;
        value_o[5:0] = status_r;
        value_o[mffsr_pkg::LONG_DESC_BIT] = 1'b1;
        value_o[mffsr_pkg::CLASS_BIT] = class_r;
        value_o[mffsr_pkg::ADDR_INV_BIT] = addr_inv_r;
    end
endmodule : mffsr_fault_rec

// ==== logic/mffsr_regs.sv ====
// Purpose: feature word and instruction fault status behind the
//          coprocessor transfer port, with hypervisor trap checks
// Assumes: one request per valid cycle, answered on the next edge
// Notes:   unmapped encodings answer with an undefined flag
module mffsr_regs #(
    parameter bit WAIT_STALL_SUPPORTED = 1'b0
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic req_valid_i,
    input wire mffsr_pkg::mffsr_req_type req_i,
    input wire mffsr_pkg::mffsr_trap_ctl_type trap_ctl_i,
    input wire mffsr_pkg::mffsr_fault_type fault_i,
    output logic rsp_valid_o,
    output logic rsp_trap_o,
    output logic rsp_undef_o,
    output logic [31:0] rsp_rdata_o
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    mffsr_pkg::mffsr_target_type target;
    logic trap;
    logic fault_we;
    logic [31:0] fault_value;
    logic [31:0] feature_word;
    logic [3:0] stall_field;
    logic rsp_valid_r;
    logic rsp_trap_r;
    logic rsp_undef_r;
    logic [31:0] rsp_rdata_r;
    logic [31:0] rdata_nxt;

    // ------------------------------------------------------------
    // feature word
    // ------------------------------------------------------------
    // stall field limited to two values
    assign stall_field = WAIT_STALL_SUPPORTED ? mffsr_pkg::STALL_YES
                                              : mffsr_pkg::STALL_NONE;

    always_comb begin
        feature_word = '0;
        feature_word[mffsr_pkg::HWACC_LSB +: 4] = mffsr_pkg::HWACC_VAL;
        feature_word[mffsr_pkg::STALL_LSB +: 4] = stall_field;
        feature_word[mffsr_pkg::BARR_LSB +: 4] = mffsr_pkg::BARR_VAL;
        feature_word[mffsr_pkg::UTLB_LSB +: 4] = mffsr_pkg::UTLB_VAL;
        feature_word[mffsr_pkg::STLB_LSB +: 4] = mffsr_pkg::STLB_VAL;
        feature_word[mffsr_pkg::RANGE_LSB +: 4] = mffsr_pkg::RANGE_VAL;
        feature_word[mffsr_pkg::BGF_LSB +: 4] = mffsr_pkg::BGF_VAL;
        feature_word[mffsr_pkg::FGF_LSB +: 4] = mffsr_pkg::FGF_VAL;
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    always_comb begin
        if (!req_valid_i || req_i.coproc != mffsr_pkg::CP_SYSTEM) begin
            target = mffsr_pkg::TGT_NONE;
        end else if (!req_i.write && req_i.opc1 == mffsr_pkg::FEAT_OPC1 &&
                     req_i.crn == mffsr_pkg::FEAT_CRN &&
                     req_i.crm == mffsr_pkg::FEAT_CRM &&
                     req_i.opc2 == mffsr_pkg::FEAT_OPC2) begin
            target = mffsr_pkg::TGT_FEATURE;
        end else if (req_i.opc1 == mffsr_pkg::FLT_OPC1 &&
                     req_i.crn == mffsr_pkg::FLT_CRN &&
                     req_i.crm == mffsr_pkg::FLT_CRM &&
                     req_i.opc2 == mffsr_pkg::FLT_OPC2) begin
            target = mffsr_pkg::TGT_FAULT;
        end else begin
            target = mffsr_pkg::TGT_NONE;
        end
    end

    mffsr_trap_chk u_trap (
        .target_i(target),
        .write_i(req_i.write),
        .level_i(req_i.level),
        .ctl_i(trap_ctl_i),
        .trap_o(trap)
    );

    assign fault_we = (target == mffsr_pkg::TGT_FAULT) && req_i.write &&
                      !trap;

    mffsr_fault_rec u_fault (
        .ref_clk_i(ref_clk_i),
        .fault_i(fault_i),
        .sw_we_i(fault_we),
        .sw_wdata_i(req_i.wdata),
        .value_o(fault_value)
    );

    // ------------------------------------------------------------
    // answer
    // ------------------------------------------------------------
    // trapped read returns nothing
    always_comb begin
        rdata_nxt = '0;
        if (!trap && !req_i.write) begin
            if (target == mffsr_pkg::TGT_FEATURE) begin
                rdata_nxt = feature_word;
            end else if (target == mffsr_pkg::TGT_FAULT) begin
                rdata_nxt = fault_value;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rsp_valid_r <= 1'b0;
        end else begin
            rsp_valid_r <= req_valid_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rsp_trap_r <= 1'b0;
            rsp_undef_r <= 1'b0;
        end else begin
            rsp_trap_r <= trap;
            rsp_undef_r <= req_valid_i && (target == mffsr_pkg::TGT_NONE);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rsp_rdata_r <= '0;
        end else begin
            rsp_rdata_r <= rdata_nxt;
        end
    end

    assign rsp_valid_o = rsp_valid_r;
    assign rsp_trap_o = rsp_trap_r;
    assign rsp_undef_o = rsp_undef_r;
    assign rsp_rdata_o = rsp_rdata_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_feat_read_ok;
        target == mffsr_pkg::TGT_FEATURE && !trap;
    endsequence

    sequence s_level1_guarded;
        req_valid_i && trap_ctl_i.hypervisor_level &&
        req_i.level == mffsr_pkg::LEVEL_ONE;
    endsequence

    sequence s_fault_read_ok;
        target == mffsr_pkg::TGT_FAULT && !req_i.write && !trap;
    endsequence

    property p_feat_fixed;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        s_feat_read_ok |=> rsp_valid_o && !rsp_trap_o &&
            rsp_rdata_o[31:28] == 4'h0 && rsp_rdata_o[23:20] == 4'h2 &&
            rsp_rdata_o[19:0] == 20'h00000;
    endproperty
    a_feat_fixed: assert property (p_feat_fixed)
        else $error("feature word fixed fields wrong");

    property p_stall_legal;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        s_feat_read_ok |=> rsp_rdata_o[27:25] == 3'h0 &&
            rsp_rdata_o[24] == WAIT_STALL_SUPPORTED;
    endproperty
    a_stall_legal: assert property (p_stall_legal)
        else $error("stall field illegal");

    property p_feat_trap;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (s_level1_guarded and target == mffsr_pkg::TGT_FEATURE &&
         (trap_ctl_i.id_group3_trap || trap_ctl_i.primary_reg0_trap))
        |=> rsp_trap_o && rsp_rdata_o == 32'h00000000;
    endproperty
    a_feat_trap: assert property (p_feat_trap)
        else $error("feature read not trapped");

    property p_fault_read_shape;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        s_fault_read_ok |=> rsp_rdata_o[9] && rsp_rdata_o[31:17] == 15'h0 &&
            rsp_rdata_o[15:13] == 3'h0 && rsp_rdata_o[11:10] == 2'h0 &&
            rsp_rdata_o[8:6] == 3'h0;
    endproperty
    a_fault_read_shape: assert property (p_fault_read_shape)
        else $error("fault status reserved bits wrong");

    property p_fault_record;
        logic [5:0] st;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (fault_i.valid, st = fault_i.status) |=> fault_value[5:0] == st;
    endproperty
    a_fault_record: assert property (p_fault_record)
        else $error("fetch fault not recorded");

    property p_addr_inv_only_sync;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        fault_i.valid && fault_i.status != mffsr_pkg::ST_SYNC_EXT
        |=> !fault_value[mffsr_pkg::ADDR_INV_BIT];
    endproperty
    a_addr_inv_only_sync: assert property (p_addr_inv_only_sync)
        else $error("address invalid set on non external fault");

    property p_class_only_external;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        fault_i.valid && !mffsr_pkg::mffsr_is_external(fault_i.status)
        |=> !fault_value[mffsr_pkg::CLASS_BIT];
    endproperty
    a_class_only_external: assert property (p_class_only_external)
        else $error("classification set on non external fault");

    property p_status_reserved;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        fault_we && !fault_i.valid &&
        !mffsr_pkg::mffsr_status_legal(req_i.wdata[5:0])
        |=> $stable(fault_value[5:0]);
    endproperty
    a_status_reserved: assert property (p_status_reserved)
        else $error("reserved status encoding stored");

    property p_fault_trap;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (s_level1_guarded and target == mffsr_pkg::TGT_FAULT &&
         (trap_ctl_i.primary_reg5_trap ||
          (req_i.write && trap_ctl_i.memory_control_write_trap) ||
          (!req_i.write && trap_ctl_i.memory_control_read_trap)))
        |=> rsp_trap_o;
    endproperty
    a_fault_trap: assert property (p_fault_trap)
        else $error("fault status access not trapped");

    property p_trap_no_change;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        target == mffsr_pkg::TGT_FAULT && req_i.write && trap &&
        !fault_i.valid |=> $stable(fault_value) ##0 rsp_trap_o;
    endproperty
    a_trap_no_change: assert property (p_trap_no_change)
        else $error("trapped write changed fault status");

    property p_trap_needs_hyp;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        req_valid_i && !trap_ctl_i.hypervisor_level |=> !rsp_trap_o;
    endproperty
    a_trap_needs_hyp: assert property (p_trap_needs_hyp)
        else $error("trap raised without hypervisor level");

    property p_trap_needs_level1;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        req_valid_i && req_i.level != mffsr_pkg::LEVEL_ONE |=> !rsp_trap_o;
    endproperty
    a_trap_needs_level1: assert property (p_trap_needs_level1)
        else $error("trap raised outside level 1");

    property p_feat_clear_no_trap;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (s_level1_guarded and target == mffsr_pkg::TGT_FEATURE &&
         !trap_ctl_i.id_group3_trap && !trap_ctl_i.primary_reg0_trap)
        |=> rsp_valid_o && !rsp_trap_o;
    endproperty
    a_feat_clear_no_trap: assert property (p_feat_clear_no_trap)
        else $error("feature read trapped with controls clear");

    property p_fault_clear_no_trap;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (s_level1_guarded and target == mffsr_pkg::TGT_FAULT &&
         !trap_ctl_i.primary_reg5_trap &&
         !(req_i.write && trap_ctl_i.memory_control_write_trap) &&
         !(!req_i.write && trap_ctl_i.memory_control_read_trap))
        |=> rsp_valid_o && !rsp_trap_o;
    endproperty
    a_fault_clear_no_trap: assert property (p_fault_clear_no_trap)
        else $error("fault status access trapped with controls clear");

    property p_trap_no_data;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        trap |=> rsp_valid_o && rsp_trap_o && !rsp_undef_o &&
            rsp_rdata_o == 32'h00000000;
    endproperty
    a_trap_no_data: assert property (p_trap_no_data)
        else $error("trapped access returned data");

    property p_sw_status_lands;
        logic [5:0] st;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (fault_we && !fault_i.valid &&
         mffsr_pkg::mffsr_status_legal(req_i.wdata[5:0]),
         st = req_i.wdata[5:0]) |=> fault_value[5:0] == st;
    endproperty
    a_sw_status_lands: assert property (p_sw_status_lands)
        else $error("legal status write not stored");

    property p_sw_addr_inv;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        fault_we && !fault_i.valid &&
        req_i.wdata[5:0] != mffsr_pkg::ST_SYNC_EXT
        |=> !fault_value[mffsr_pkg::ADDR_INV_BIT];
    endproperty
    a_sw_addr_inv: assert property (p_sw_addr_inv)
        else $error("address invalid kept on non external write");

    property p_sw_class;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        fault_we && !fault_i.valid &&
        !mffsr_pkg::mffsr_is_external(req_i.wdata[5:0])
        |=> !fault_value[mffsr_pkg::CLASS_BIT];
    endproperty
    a_sw_class: assert property (p_sw_class)
        else $error("classification kept on non external write");

    property p_fault_value_shape;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        fault_value[mffsr_pkg::LONG_DESC_BIT] &&
        fault_value[31:17] == 15'h0 && fault_value[15:13] == 3'h0 &&
        fault_value[11:10] == 2'h0 && fault_value[8:6] == 3'h0;
    endproperty
    a_fault_value_shape: assert property (p_fault_value_shape)
        else $error("fault status fixed bits wrong");

    property p_fault_beats_write;
        logic [5:0] st;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (fault_i.valid && fault_we, st = fault_i.status)
        |=> fault_value[5:0] == st;
    endproperty
    a_fault_beats_write: assert property (p_fault_beats_write)
        else $error("software write beat a fetch fault");

    property p_fault_addr_inv_kept;
        logic v;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (fault_i.valid && fault_i.status == mffsr_pkg::ST_SYNC_EXT,
         v = fault_i.fault_address_invalid)
        |=> fault_value[mffsr_pkg::ADDR_INV_BIT] == v;
    endproperty
    a_fault_addr_inv_kept: assert property (p_fault_addr_inv_kept)
        else $error("address invalid flag lost");

    property p_fault_class_kept;
        logic x;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (fault_i.valid && mffsr_pkg::mffsr_is_external(fault_i.status),
         x = fault_i.abort_classification_bit)
        |=> fault_value[mffsr_pkg::CLASS_BIT] == x;
    endproperty
    a_fault_class_kept: assert property (p_fault_class_kept)
        else $error("classification bit lost");

endmodule : mffsr_regs

// ==== tb/mffsr_regs_tb_top.sv ====
// Purpose: self-checking bench for the feature word and fault status bank
// Assumes: one request per call, answer one edge after it is taken
// Notes:   fault status is not read until a fault or write has set it
module mffsr_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // signals and instance
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    mffsr_pkg::mffsr_req_type req = '0;
    mffsr_pkg::mffsr_trap_ctl_type trap_ctl = '0;
    mffsr_pkg::mffsr_fault_type fault = '0;
    logic rsp_valid;
    logic rsp_trap;
    logic rsp_undef;
    logic [31:0] rsp_rdata;
    logic [31:0] stall_rdata;
    int n_mismatch = 0;
    int samples_checked = 0;

    always #25 clk = ~clk;

    mffsr_regs #(.WAIT_STALL_SUPPORTED(1'b0)) uut (
        .ref_clk_i(clk),
        .rst_n_i(rst_n),
        .req_valid_i(req_valid),
        .req_i(req),
        .trap_ctl_i(trap_ctl),
        .fault_i(fault),
        .rsp_valid_o(rsp_valid),
        .rsp_trap_o(rsp_trap),
        .rsp_undef_o(rsp_undef),
        .rsp_rdata_o(rsp_rdata)
    );

    // second build, stall field reporting support
    mffsr_regs #(.WAIT_STALL_SUPPORTED(1'b1)) uut_stall (
        .ref_clk_i(clk),
        .rst_n_i(rst_n),
        .req_valid_i(req_valid),
        .req_i(req),
        .trap_ctl_i(trap_ctl),
        .fault_i(fault),
        .rsp_valid_o(),
        .rsp_trap_o(),
        .rsp_undef_o(),
        .rsp_rdata_o(stall_rdata)
    );

    // ------------------------------------------------------------
    // compare and bus tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one access; answer sampled just after the edge that follows
    task automatic acc(input logic w, input logic [1:0] lv,
                       input logic [3:0] cp, input logic [3:0] crn,
                       input logic [3:0] crm, input logic [2:0] o2,
                       input logic [31:0] wd, input logic exp_trap,
                       input logic exp_undef, input logic [31:0] exp_d);
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{write: w, level: lv, coproc: cp, opc1: 3'h0, crn: crn,
                 crm: crm, opc2: o2, wdata: wd};
        @(posedge clk);
        req_valid <= 1'b0;
        #1;
        chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
        chk("rsp_trap", {31'h0, exp_trap}, {31'h0, rsp_trap});
        chk("rsp_undef", {31'h0, exp_undef}, {31'h0, rsp_undef});
        chk("rsp_rdata", exp_d, rsp_rdata);
    endtask : acc

    task automatic rd_feat(input logic [1:0] lv, input logic t,
                           input logic [31:0] d);
        acc(1'b0, lv, 4'hf, 4'h0, 4'h1, 3'h6, 32'h0, t, 1'b0, d);
    endtask : rd_feat

    task automatic rd_flt(input logic [1:0] lv, input logic t,
                          input logic [31:0] d);
        acc(1'b0, lv, 4'hf, 4'h5, 4'h0, 3'h1, 32'h0, t, 1'b0, d);
    endtask : rd_flt

    task automatic wr_flt(input logic [1:0] lv, input logic t,
                          input logic [31:0] wd);
        acc(1'b1, lv, 4'hf, 4'h5, 4'h0, 3'h1, wd, t, 1'b0, 32'h0);
    endtask : wr_flt

    task automatic inject(input logic [5:0] s, input logic x,
                          input logic v);
        @(posedge clk);
        fault <= '{valid: 1'b1, status: s, abort_classification_bit: x,
                   fault_address_invalid: v};
        @(posedge clk);
        fault.valid <= 1'b0;
    endtask : inject

    // expected read value worked out from the field layout
    function automatic logic [31:0] fexp(input logic [5:0] s,
                                         input logic x, input logic v);
        logic extern_abort;
        extern_abort = (s == 6'h10) || (s == 6'h18);
        return 32'h0000_0200 | {26'h0, s} |
               ((v && s == 6'h10) ? 32'h0001_0000 : 32'h0) |
               ((x && extern_abort) ? 32'h0000_1000 : 32'h0);
    endfunction : fexp

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_feature();
        rd_feat(2'h1, 1'b0, 32'h0020_0000);
        chk("stall_rdata", 32'h0120_0000, stall_rdata);
        rd_feat(2'h0, 1'b0, 32'h0020_0000);
        acc(1'b1, 2'h1, 4'hf, 4'h0, 4'h1, 3'h6, 32'hffff_ffff,
            1'b0, 1'b1, 32'h0);
        acc(1'b0, 2'h1, 4'he, 4'h0, 4'h1, 3'h6, 32'h0,
            1'b0, 1'b1, 32'h0);
        acc(1'b0, 2'h1, 4'hf, 4'h0, 4'h1, 3'h7, 32'h0,
            1'b0, 1'b1, 32'h0);
        $display("test_feature done");
    endtask : test_feature

    task automatic test_fault_codes();
        logic [5:0] codes [6] = '{6'h04, 6'h0c, 6'h10, 6'h18, 6'h21, 6'h22};
        foreach (codes[i]) begin
            inject(codes[i], 1'b1, 1'b1);
            rd_flt(2'h1, 1'b0, fexp(codes[i], 1'b1, 1'b1));
            inject(codes[i], 1'b0, 1'b0);
            rd_flt(2'h1, 1'b0, fexp(codes[i], 1'b0, 1'b0));
        end
        $display("test_fault_codes done");
    endtask : test_fault_codes

    task automatic test_sw_write();
        wr_flt(2'h1, 1'b0, 32'hffff_ffcc);
        rd_flt(2'h1, 1'b0, 32'h0000_020c);
        wr_flt(2'h1, 1'b0, 32'h0001_1010);
        rd_flt(2'h1, 1'b0, 32'h0001_1210);
        // reserved code keeps the old status field
        wr_flt(2'h1, 1'b0, 32'h0000_003f);
        rd_flt(2'h1, 1'b0, 32'h0000_0210);
        // fetch fault and write taken on the same edge: fault wins
        fork
            inject(6'h0c, 1'b0, 1'b0);
            acc(1'b1, 2'h1, 4'hf, 4'h5, 4'h0, 3'h1, 32'h0000_0004,
                1'b0, 1'b0, 32'h0);
        join
        rd_flt(2'h1, 1'b0, 32'h0000_020c);
        $display("test_sw_write done");
    endtask : test_sw_write

    task automatic test_traps();
        logic [5:0] fc [4] = '{6'h30, 6'h28, 6'h10, 6'h08};
        logic ft [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
        foreach (fc[i]) begin
            trap_ctl <= mffsr_pkg::mffsr_trap_ctl_type'(fc[i]);
            rd_feat(2'h1, ft[i], ft[i] ? 32'h0 : 32'h0020_0000);
        end
        trap_ctl <= mffsr_pkg::mffsr_trap_ctl_type'(6'h3f);
        rd_feat(2'h2, 1'b0, 32'h0020_0000);
        trap_ctl <= '0;
        wr_flt(2'h1, 1'b0, 32'h0000_0004);
        trap_ctl <= mffsr_pkg::mffsr_trap_ctl_type'(6'h24);
        wr_flt(2'h1, 1'b1, 32'h0000_000c);
        rd_feat(2'h1, 1'b0, 32'h0020_0000);
        rd_flt(2'h1, 1'b0, 32'h0000_0204);
        trap_ctl <= mffsr_pkg::mffsr_trap_ctl_type'(6'h22);
        rd_flt(2'h1, 1'b1, 32'h0);
        wr_flt(2'h1, 1'b0, 32'h0000_0021);
        trap_ctl <= mffsr_pkg::mffsr_trap_ctl_type'(6'h21);
        wr_flt(2'h1, 1'b1, 32'h0000_0022);
        rd_flt(2'h1, 1'b1, 32'h0);
        trap_ctl <= '0;
        rd_flt(2'h1, 1'b0, 32'h0000_0221);
        $display("test_traps done");
    endtask : test_traps

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    // about 115 cycles of traffic; generous margin
    initial begin
        #(2000 * 50);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk("rsp_after_reset", 32'h0, {29'h0, rsp_valid, rsp_trap, rsp_undef});
        test_feature();
        test_fault_codes();
        test_sw_write();
        test_traps();
        report_and_stop();
    end
endmodule : mffsr_regs_tb_top
